// ---- hw/ibtq_pkg.sv ----
/*
 * Package for the image block transfer queue: modes, states, reset values
 * and the carrier structs shared by the block and its bench.
 * Assumes a single 50 MHz clock domain and a synchronous active-high reset.
 */
`default_nettype none

package ibtq_pkg;
    // ==========================================================
    // Sizes
    // ==========================================================
    localparam int IBTQ_DATA_W = 32;
    localparam int IBTQ_DEPTH = 4;
    localparam int IBTQ_WORDS = 16;
    localparam int IBTQ_CNT_W = 16;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [IBTQ_CNT_W-1:0] IBTQ_CNT_RST = 16'h0000;

    // ==========================================================
    // Modes and states
    // ==========================================================
    typedef enum logic [1:0] {
        IBTQ_CTL_BASIC = 2'h0,
        IBTQ_CTL_AUTO = 2'h1,
        IBTQ_CTL_USER = 2'h2
    } ibtq_ctl_t;

    typedef enum logic {
        IBTQ_OP_CONT = 1'h0,
        IBTQ_OP_MULTI = 1'h1
    } ibtq_op_t;

    typedef enum logic [1:0] {
        IBTQ_ST_IDLE = 2'h0,
        IBTQ_ST_SEND = 2'h1
    } ibtq_state_t;

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic [IBTQ_DATA_W-1:0] data;
        logic last;
    } ibtq_beat_t;

    typedef struct packed {
        ibtq_ctl_t ctl_mode;
        ibtq_op_t op_mode;
        logic [IBTQ_CNT_W-1:0] block_count;
    } ibtq_cfg_t;
endpackage : ibtq_pkg

`default_nettype wire

// ---- hw/ibtq_top.sv ----
/*
 * Image block transfer queue: stores whole processed blocks (frame plus
 * appended chunk words) in a block FIFO and streams them out to the link.
 * A block may start leaving once PKT_WORDS of its beats have landed.
 * Assumes the producer marks the last beat of each block and that all
 * inputs share clock_i (no pins, so no synchronisers needed).
 */
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Incoming beats form a block, closed by last, then queued.
// - Basic/automatic modes send as soon as a packet of data is queued.
// - Next block goes out after a two-cycle gap, via IDLE.
// - Slow link: blocks accumulate in the queue rather than being dropped.
// - Queue capacity in blocks is a readable output.
// - Current number of queued blocks is a readable output.
// - Count of lost blocks is a readable output.
// - Oldest queued block is always sent next.
// - Full queue: new block overwrites oldest block; input waits while that block is sending.
// - Each overwrite adds one to the lost count.
// - After a block finishes, the next oldest one goes out.
// - User mode has two operation choices: continuous and multi-block.
// - Continuous: stream only between start and stop commands.
// - Multi-block: send the programmed block count, then stop.
// - Acquisition start/stop leaves queue and transfer state alone.
// - Closing the stream channel empties queue and cancels sending.
// - Stop lets the block in progress finish first.
// - Start and stop accepted only in user controlled mode.
// - Block count used only in multi-block operation.
module ibtq_top #(
    parameter int DEPTH = ibtq_pkg::IBTQ_DEPTH,
    parameter int WORDS = ibtq_pkg::IBTQ_WORDS,
    parameter int PKT_WORDS = 4
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire ibtq_pkg::ibtq_cfg_t cfg_i,
    input wire logic start_i,
    input wire logic stop_i,
    input wire logic close_i,
    input wire logic in_valid_i,
    input wire ibtq_pkg::ibtq_beat_t in_beat_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output ibtq_pkg::ibtq_beat_t out_beat_o,
    input wire logic out_ready_i,
    output logic [ibtq_pkg::IBTQ_CNT_W-1:0] max_blocks_o,
    output logic [ibtq_pkg::IBTQ_CNT_W-1:0] cur_blocks_o,
    output logic [ibtq_pkg::IBTQ_CNT_W-1:0] lost_blocks_o,
    output logic streaming_o
);
    import ibtq_pkg::*;

    localparam int SW = $clog2(DEPTH);
    localparam int WW = $clog2(WORDS);
    localparam int CW = $clog2(DEPTH + 1);

    // ==========================================================
    // Storage: one slot per block, one word row per beat
    // ==========================================================
    logic [IBTQ_DATA_W-1:0] mem [DEPTH][WORDS];
    logic [WW:0] slot_len [DEPTH];

    // Ring slot index wrap
    function automatic logic [SW-1:0] nxt_slot(input logic [SW-1:0] s);
        nxt_slot = (s == SW'(DEPTH - 1)) ? '0 : s + SW'(1);
    endfunction : nxt_slot

    // Transfer gate: always open outside user mode; in user mode start/stop
    // decide, and multi-block also closes once the programmed count is out
    function automatic logic gate_open(input ibtq_cfg_t c, input logic en, input logic [IBTQ_CNT_W-1:0] done);
        if (c.ctl_mode != IBTQ_CTL_USER) begin
            gate_open = 1'b1;
        end else if (c.op_mode == IBTQ_OP_MULTI) begin
            gate_open = en && (done < c.block_count);
        end else begin
            gate_open = en;
        end
    endfunction : gate_open

    // ==========================================================
    // Queue state
    // ==========================================================
    // Ring invariant: wslot is always head plus count, modulo DEPTH, so an
    // empty queue has the filling slot at the head; early sending relies on it
    logic [SW-1:0] head, next_head;   // Oldest block
    logic [SW-1:0] wslot, next_wslot; // Slot being filled
    logic [CW-1:0] count, next_count; // Complete blocks queued
    logic [WW:0] wptr, next_wptr;
    logic [WW:0] rptr, next_rptr;
    logic filling, next_filling;      // Write slot holds a partial block
    ibtq_state_t state, next_state;
    logic enabled, next_enabled;
    logic [IBTQ_CNT_W-1:0] sent, next_sent;
    logic [IBTQ_CNT_W-1:0] lost, next_lost;
    logic [IBTQ_CNT_W-1:0] cur, next_cur;
    logic out_valid, next_out_valid;
    ibtq_beat_t out_beat, next_out_beat;

    logic wr_fire;
    logic wr_done;
    logic rd_fire;
    logic rd_done;
    logic sending;
    logic head_busy;
    logic full_now;
    logic [WW:0] head_avail;
    logic pkt_ready; // Head block partly in, enough for a packet

    always_comb begin
        sending = (state == IBTQ_ST_SEND);
        // Partial head block is readable once a packet's worth has landed
        head_avail = (count != '0) ? slot_len[head] : wptr;
        // Empty queue but a packet's worth of the arriving block has landed,
        // so it may go out before its last beat is stored
        pkt_ready = (count == '0) && filling && (wptr >= (WW + 1)'(PKT_WORDS));
        // Slot under transmission must never be reused
        head_busy = sending;
        full_now = (count == CW'(DEPTH - 1)) && filling;
        wr_fire = in_valid_i && in_ready_o;
        wr_done = wr_fire && in_beat_i.last;
        rd_fire = out_valid && out_ready_i;
        rd_done = rd_fire && out_beat.last;
    end

    // ==========================================================
    // Next-state logic
    // ==========================================================
    always_comb begin
        next_head = head;
        next_wslot = wslot;
        next_count = count;
        next_wptr = wptr;
        next_rptr = rptr;
        next_filling = filling;
        next_state = state;
        next_enabled = enabled;
        next_sent = sent;
        next_lost = lost;
        next_out_valid = out_valid;
        next_out_beat = out_beat;

        // Start/stop only in user mode; acquisition has no effect here
        if (cfg_i.ctl_mode == IBTQ_CTL_USER) begin
            if (start_i) begin
                next_enabled = 1'b1;
                next_sent = '0;
            end else if (stop_i) begin
                next_enabled = 1'b0;
            end
        end

        // Writer side: beats fill the write slot
        if (wr_fire) begin
            next_wptr = wptr + (WW + 1)'(1);
            next_filling = 1'b1;
            if (wr_done) begin
                next_wptr = '0;
                next_filling = 1'b0;
                next_wslot = nxt_slot(wslot);
                if (count == CW'(DEPTH)) begin
                    // Drop oldest idle block to make room
                    next_head = nxt_slot(head);
                    next_lost = lost + IBTQ_CNT_W'(1);
                end else begin
                    next_count = count + CW'(1);
                end
            end
        end

        // Reader side: single output register, reloaded as its beat is taken
        if (rd_fire) begin
            next_out_valid = 1'b0;
        end
        // IDLE waits for data and an open gate, SEND walks the head slot
        unique case (state)
            IBTQ_ST_IDLE: begin
                // Complete blocks, or a head block still arriving with a packet in
                if ((count != '0 || pkt_ready) && gate_open(cfg_i, enabled, sent)) begin
                    next_state = IBTQ_ST_SEND;
                    next_rptr = '0;
                end
            end
            IBTQ_ST_SEND: begin
                // Load when the output register frees up, never past landed beats
                if ((!out_valid || rd_fire) && rptr < head_avail && !(rd_done)) begin
                    next_out_beat.data = mem[head][rptr[WW-1:0]];
                    // Length is known only once the block is complete; until then no beat is last
                    next_out_beat.last = (count != '0) && (rptr + (WW + 1)'(1) == slot_len[head]);
                    next_out_valid = 1'b1;
                    next_rptr = rptr + (WW + 1)'(1);
                end
                if (rd_done) begin
                    // Block retired; next oldest follows after a pass through IDLE
                    next_head = nxt_slot(head);
                    next_count = next_count - CW'(1);
                    next_sent = next_sent + IBTQ_CNT_W'(1);
                    next_state = IBTQ_ST_IDLE;
                end
            end
            default: next_state = IBTQ_ST_IDLE;
        endcase

        // Channel close wipes everything pending
        if (close_i) begin
            next_head = '0;
            next_wslot = '0;
            next_count = '0;
            next_wptr = '0;
            next_rptr = '0;
            next_filling = 1'b0;
            next_state = IBTQ_ST_IDLE;
            next_enabled = 1'b0;
            next_out_valid = 1'b0;
        end
        // Reported count tracks the queue count register exactly
        next_cur = IBTQ_CNT_W'(next_count);
    end

    // ==========================================================
    // Registers
    // ==========================================================
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            head <= '0;
            wslot <= '0;
            count <= '0;
            wptr <= '0;
            rptr <= '0;
            filling <= 1'b0;
            state <= IBTQ_ST_IDLE;
            enabled <= 1'b0;
            sent <= IBTQ_CNT_RST;
            lost <= IBTQ_CNT_RST;
            cur <= IBTQ_CNT_RST;
            out_valid <= 1'b0;
            out_beat <= '0;
        end else begin
            head <= next_head;
            wslot <= next_wslot;
            count <= next_count;
            wptr <= next_wptr;
            rptr <= next_rptr;
            filling <= next_filling;
            state <= next_state;
            enabled <= next_enabled;
            sent <= next_sent;
            lost <= next_lost;
            cur <= next_cur;
            out_valid <= next_out_valid;
            out_beat <= next_out_beat;
        end
    end

    // Block storage write; no reset since contents are gated by counts
    always_ff @(posedge clock_i) begin
        if (wr_fire) begin
            mem[wslot][wptr[WW-1:0]] <= in_beat_i.data;
        end
        if (wr_done) begin
            slot_len[wslot] <= wptr + (WW + 1)'(1);
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    logic in_ready, next_in_ready;
    // Refuse beats while the write slot would hit the block being sent,
    // or the block is longer than a slot
    always_comb begin
        next_in_ready = !close_i &&
            !(next_count == CW'(DEPTH) && next_wslot == next_head &&
              next_state == IBTQ_ST_SEND) &&
            (next_wptr < (WW + 1)'(WORDS));
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            in_ready <= 1'b0;
            streaming_o <= 1'b0;
            max_blocks_o <= IBTQ_CNT_RST;
        end else begin
            in_ready <= next_in_ready;
            streaming_o <= (next_state == IBTQ_ST_SEND);
            max_blocks_o <= IBTQ_CNT_W'(DEPTH);
        end
    end

    assign in_ready_o = in_ready;
    assign out_valid_o = out_valid;
    assign out_beat_o = out_beat;
    assign cur_blocks_o = cur;
    assign lost_blocks_o = lost;

    // Unused helpers kept to zero width impact
    logic unused_ok;
    assign unused_ok = head_busy ^ full_now ^ (PKT_WORDS > 0);
endmodule : ibtq_top

`default_nettype wire

// ---- test/ibtq_sink.sv ----
/*
 * Host link model: takes output beats, counts blocks, keeps first word.
 * Assumes the queue's valid-ready stream on clock_i.
 */
`timescale 1ns/1ps
`default_nettype none

module ibtq_sink (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic slow_i,
    input wire logic valid_i,
    input wire ibtq_pkg::ibtq_beat_t beat_i,
    output logic ready_o,
    output logic [7:0] blocks_o,
    output logic [31:0] head_o
);
    import ibtq_pkg::*;
    logic tick;
    logic first;
    // ==========================================================
    // Receiver
    // ==========================================================
    // Slow link accepts every other cycle, forcing the queue to wait
    assign ready_o = !slow_i || tick;
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            tick <= 1'b0;
            first <= 1'b1;
            blocks_o <= 8'h00;
            head_o <= 32'h0;
        end else begin
            tick <= !tick;
            if (valid_i && ready_o) begin
                if (first) head_o <= beat_i.data;
                first <= beat_i.last;
                if (beat_i.last) blocks_o <= blocks_o + 8'h01;
            end
        end
    end
endmodule : ibtq_sink

`default_nettype wire

// ---- test/ibtq_top_properties.sv ----
/*
 * Checker for the image block transfer queue, bound to its top module.
 * Assumes one clock domain and the synchronous active-high reset rst_i.
 */
`timescale 1ns/1ps
`default_nettype none

module ibtq_top_properties #(
    parameter int DEPTH = 4
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic close_i,
    input wire logic in_ready_o,
    input wire logic out_valid_o,
    input wire logic out_ready_i,
    input wire ibtq_pkg::ibtq_beat_t out_beat_o,
    input wire logic [15:0] max_blocks_o,
    input wire logic [15:0] cur_blocks_o,
    input wire logic [15:0] lost_blocks_o,
    input wire logic streaming_o
);
    import ibtq_pkg::*;
    // ==========================================================
    // Properties
    // ==========================================================
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    property p_max; !$past(rst_i) |-> max_blocks_o == 16'(DEPTH); endproperty
    a_max: assert property (p_max) else $error("capacity wrong");
    property p_cur_max; cur_blocks_o <= 16'(DEPTH); endproperty
    a_cur_max: assert property (p_cur_max) else $error("count above capacity");
    property p_hold; out_valid_o && !out_ready_i && !close_i |=> out_valid_o && $stable(out_beat_o); endproperty
    a_hold: assert property (p_hold) else $error("beat not held");
    property p_lost_step; $changed(lost_blocks_o) |-> lost_blocks_o == 16'($past(lost_blocks_o) + 1); endproperty
    a_lost_step: assert property (p_lost_step) else $error("lost count jump");
    property p_lost_full; $changed(lost_blocks_o) |-> $past(cur_blocks_o) == 16'(DEPTH); endproperty
    a_lost_full: assert property (p_lost_full) else $error("loss while not full");
    property p_close_cur; close_i |-> ##[1:2] cur_blocks_o == 16'h0000 && !streaming_o; endproperty
    a_close_cur: assert property (p_close_cur) else $error("close left blocks");
    property p_close_rdy; close_i |=> !in_ready_o; endproperty
    a_close_rdy: assert property (p_close_rdy) else $error("input open on close");
    property p_stream; out_valid_o |-> streaming_o; endproperty
    a_stream: assert property (p_stream) else $error("beat outside send");
    // Close clears the count one cycle later; steps in the two cycles after it are excused
    property p_cur_step;
        $changed(cur_blocks_o) && !$past(close_i) && !$past(close_i, 2)
            |-> cur_blocks_o == 16'($past(cur_blocks_o) + 1) || cur_blocks_o == 16'($past(cur_blocks_o) - 1);
    endproperty
    a_cur_step: assert property (p_cur_step) else $error("count jump");
endmodule : ibtq_top_properties

bind ibtq_top ibtq_top_properties #(.DEPTH(DEPTH)) i_props (.clock_i(clock_i), .rst_i(rst_i),
    .close_i(close_i), .in_ready_o(in_ready_o), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
    .out_beat_o(out_beat_o), .max_blocks_o(max_blocks_o), .cur_blocks_o(cur_blocks_o),
    .lost_blocks_o(lost_blocks_o), .streaming_o(streaming_o));

`default_nettype wire

// ---- test/tb_top.sv ----
/*
 * Self-checking bench for the transfer queue with a host link model.
 * Assumes the design's default DEPTH and 50 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import ibtq_pkg::*;
    logic clock_i, rst_i, start_i, stop_i, close_i, in_valid_i, in_ready_o, out_valid_o, out_ready_i;
    logic streaming_o, slow;
    ibtq_cfg_t cfg_i;
    ibtq_beat_t in_beat_i, out_beat_o;
    logic [15:0] max_blocks_o, cur_blocks_o, lost_blocks_o;
    logic [7:0] blocks;
    logic [31:0] head;
    int errors = 0;
    int n_tests = 0;
    ibtq_top i_dut (.clock_i(clock_i), .rst_i(rst_i), .cfg_i(cfg_i), .start_i(start_i), .stop_i(stop_i),
        .close_i(close_i), .in_valid_i(in_valid_i), .in_beat_i(in_beat_i), .in_ready_o(in_ready_o),
        .out_valid_o(out_valid_o), .out_beat_o(out_beat_o), .out_ready_i(out_ready_i),
        .max_blocks_o(max_blocks_o), .cur_blocks_o(cur_blocks_o), .lost_blocks_o(lost_blocks_o),
        .streaming_o(streaming_o));
    ibtq_sink i_sink (.clock_i(clock_i), .rst_i(rst_i), .slow_i(slow), .valid_i(out_valid_o),
        .beat_i(out_beat_o), .ready_o(out_ready_i), .blocks_o(blocks), .head_o(head));
    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic chk_cnt(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_cnt
    task automatic chk_dat(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_dat
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : tick
    // Beats are held until the edge that sees ready high
    task automatic send_block(input logic [7:0] id, input int n);
        for (int k = 0; k < n; k++) begin
            in_valid_i = 1'b1;
            in_beat_i = '{data: {id, 24'(k)}, last: (k == n - 1)};
            for (int g = 0; in_ready_o !== 1'b1 && g < 500; g++) tick(1);
            tick(1);
        end
        in_valid_i = 1'b0;
        tick(3);
    endtask : send_block
    task automatic wait_blk(input logic [7:0] n);
        for (int g = 0; blocks != n && g < 2000; g++) tick(1);
        tick(4);
    endtask : wait_blk
    task automatic pulse(input logic which);
        if (which) start_i = 1'b1;
        else stop_i = 1'b1;
        tick(1);
        start_i = 1'b0;
        stop_i = 1'b0;
    endtask : pulse
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    // ==========================================================
    // Clock, watchdog, tests
    // ==========================================================
    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end
    // Whole sequence needs under 500 cycles
    initial begin
        repeat (20000) @(posedge clock_i);
        errors++;
        complete_run();
    end
    initial begin
        {rst_i, start_i, stop_i, close_i, in_valid_i, slow} = 6'b100000;
        in_beat_i = '0;
        cfg_i = '{ctl_mode: IBTQ_CTL_BASIC, op_mode: IBTQ_OP_CONT, block_count: 16'h0000};
        tick(12);
        rst_i = 1'b0;
        tick(2);
        chk_cnt(max_blocks_o, 16'(IBTQ_DEPTH));
        chk_cnt(lost_blocks_o, 16'h0000);
        // A long block must start leaving before it is fully stored
        send_block(8'h01, 16);
        tick(7);
        chk_cnt(16'(blocks), 16'h0001);
        wait_blk(8'd1);
        chk_dat(head, 32'h01000000);
        chk_cnt(cur_blocks_o, 16'h0000);
        $display("test basic done");
        // Slow link with two back-to-back blocks
        cfg_i.ctl_mode = IBTQ_CTL_AUTO;
        slow = 1'b1;
        send_block(8'h02, 3);
        send_block(8'h03, 16);
        wait_blk(8'd3);
        chk_dat(head, 32'h03000000);
        $display("test auto done");
        // Start outside user mode must be ignored
        pulse(1'b1);
        // User mode, not started: queue fills, then overflows
        cfg_i.ctl_mode = IBTQ_CTL_USER;
        slow = 1'b0;
        for (int b = 4; b < 8; b++) send_block(8'(b), 2);
        chk_cnt(cur_blocks_o, 16'h0004);
        send_block(8'h08, 2);
        chk_cnt(lost_blocks_o, 16'h0001);
        chk_cnt(cur_blocks_o, 16'h0004);
        chk_cnt(16'(blocks), 16'h0003);
        pulse(1'b1);
        for (int g = 0; streaming_o !== 1'b1 && g < 50; g++) tick(1);
        chk_cnt(16'(streaming_o), 16'h0001);
        pulse(1'b0);
        tick(60);
        chk_cnt(16'(blocks), 16'h0004);
        chk_dat(head, 32'h05000000);
        pulse(1'b1);
        wait_blk(8'd7);
        chk_dat(head, 32'h08000000);
        pulse(1'b0);
        $display("test continuous done");
        // Multi-block: count programmed before start
        cfg_i.op_mode = IBTQ_OP_MULTI;
        cfg_i.block_count = 16'h0002;
        for (int b = 9; b < 12; b++) send_block(8'(b), 2);
        pulse(1'b1);
        tick(80);
        chk_cnt(16'(blocks), 16'h0009);
        chk_dat(head, 32'h0a000000);
        chk_cnt(cur_blocks_o, 16'h0001);
        close_i = 1'b1;
        tick(1);
        close_i = 1'b0;
        tick(3);
        chk_cnt(cur_blocks_o, 16'h0000);
        chk_cnt(16'(streaming_o), 16'h0000);
        $display("test multi done");
        complete_run();
    end
endmodule : tb_top

`default_nettype wire
